// [hdl/rss_pkg.sv]
// package: constants shared by both ends of the reset/strap/select link
package rss_pkg;
  // mode decoded from the two protocol straps
  typedef enum logic [1:0] {
    RSS_MODE_NATIVE,
    RSS_MODE_ALT_A,
    RSS_MODE_ALT_B,
    RSS_MODE_ALT_C
  } rss_mode_t;
  // decoded local-bus target of a cycle
  typedef enum logic [1:0] {
    RSS_TGT_NONE,
    RSS_TGT_REGS,
    RSS_TGT_IMAGE0,
    RSS_TGT_IMAGE1
  } rss_tgt_t;
  // device register space (byte offsets of 32-bit registers on the local bus)
  localparam logic [7:0] RSS_OFS_MISC_CONTROL_REG = 8'h00;
  localparam logic [7:0] RSS_OFS_MISC_CONTROL_SECOND_REG = 8'h04;
  localparam logic [7:0] RSS_OFS_CMD_STAT = 8'h08;
  localparam logic [7:0] RSS_OFS_STRAPS = 8'h0C;
  // field positions
  localparam int RSS_BIT_SOFT_RST = 0;
  localparam int RSS_BIT_HOST_DIS = 0;
  localparam int RSS_BIT_ARB_EN = 1;
  localparam int RSS_BIT_MASTER_EN = 2;
  // host controller register space
  localparam logic [7:0] RSS_HOFS_CTRL = 8'h00;
  localparam logic [7:0] RSS_HOFS_ADDR = 8'h04;
  localparam logic [7:0] RSS_HOFS_WDATA = 8'h08;
  localparam logic [7:0] RSS_HOFS_STATUS = 8'h0C;
  localparam logic [7:0] RSS_HOFS_RDATA = 8'h10;
  localparam logic [7:0] RSS_HOFS_CONFIG = 8'h14;
  // ctrl field positions (host)
  localparam int RSS_HC_GO = 0;
  localparam int RSS_HC_WRITE = 1;
  localparam int RSS_HC_BRIDGE = 2;
  localparam int RSS_HC_IMAGE = 3;
  localparam int RSS_HC_BURST = 4;
  localparam int RSS_HC_HRESET = 5;
  localparam int RSS_HC_LRESET = 6;
  localparam int RSS_HC_HOTSWAP = 7;
  // processor interface setup at reset
  localparam logic [1:0] RSS_MULTIPIN_RETRY = 2'h2;
  localparam logic [31:0] RSS_ZERO32 = 32'h0000_0000;
  localparam logic [3:0] RSS_BURST_BEATS = 4'h4;
endpackage

// [hdl/rss_link_if.sv]
// interface: pins between bridge device and processor-side controller
interface rss_link_if;
  logic host_hard_reset_n;
  logic local_reset_in_n;
  logic hot_swap_ok_n;
  logic reset_out_n;
  logic reg_chip_select_n;
  logic bridge_chip_select_n;
  logic image_select;
  logic burst_in_progress_n;
  logic size_bit_one;
  logic write_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ta_n;
  logic retry_n;
  logic addr_strobe_n;
  logic size_ack0_n;
  logic done_n;
  logic master_enable_strap;
  logic arbiter_enable_strap;
  logic host_bus_disable_strap;

  modport dev (
    input host_hard_reset_n, local_reset_in_n, hot_swap_ok_n,
    input reg_chip_select_n, bridge_chip_select_n, image_select,
    input burst_in_progress_n, size_bit_one, write_n, addr, wdata,
    input addr_strobe_n, size_ack0_n, done_n,
    input master_enable_strap, arbiter_enable_strap, host_bus_disable_strap,
    output reset_out_n, rdata, ta_n, retry_n
  );
  modport host (
    output host_hard_reset_n, local_reset_in_n, hot_swap_ok_n,
    output reg_chip_select_n, bridge_chip_select_n, image_select,
    output burst_in_progress_n, size_bit_one, write_n, addr, wdata,
    output addr_strobe_n, size_ack0_n, done_n,
    output master_enable_strap, arbiter_enable_strap, host_bus_disable_strap,
    input reset_out_n, rdata, ta_n, retry_n
  );
endinterface

// [hdl/rss_device.sv]
// bridge device end: strap capture, reset output and chip-select decode
//
// Added by the designer: the plain strobed port and the register addresses.
module rss_device (
  input wire logic clk_i,
  input wire logic srst_i,
  rss_link_if.dev link,
  output rss_pkg::rss_mode_t mode_o,
  output rss_pkg::rss_tgt_t target_o,
  output logic target_valid_o,
  output logic master_enable_o,
  output logic arbiter_enable_o,
  output logic host_bus_disable_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] pins_raw;
  assign pins_raw = {link.host_hard_reset_n, link.local_reset_in_n, link.hot_swap_ok_n,
                     link.burst_in_progress_n, link.size_bit_one,
                     link.master_enable_strap, link.arbiter_enable_strap};
  always_ff @(posedge clk_i) begin
    sync1_reg <= pins_raw;
    sync2_reg <= sync1_reg;
  end
  logic hard_n;
  logic lrst_n;
  logic hs_n;
  assign hard_n = sync2_reg[6];
  assign lrst_n = sync2_reg[5];
  assign hs_n = sync2_reg[4];
  logic dis_s1_reg;
  logic dis_s2_reg;
  always_ff @(posedge clk_i) begin
    dis_s1_reg <= link.host_bus_disable_strap;
    dis_s2_reg <= dis_s1_reg;
  end

  // ----------------------------------------------------------------
  // reset events
  // ----------------------------------------------------------------
  logic hard_d_reg;
  logic lrst_d_reg;
  logic hs_d_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hard_d_reg <= 1'b0;
      lrst_d_reg <= 1'b0;
      hs_d_reg <= 1'b1;
    end else begin
      hard_d_reg <= hard_n;
      lrst_d_reg <= lrst_n;
      hs_d_reg <= hs_n;
    end
  end
  logic hard_active;
  logic capture_evt;
  assign hard_active = ~hard_n;
  assign capture_evt = (hard_n & ~hard_d_reg) | (lrst_n & ~lrst_d_reg) | (~hs_n & hs_d_reg);

  // ----------------------------------------------------------------
  // strap latches
  // ----------------------------------------------------------------
  logic burst_in_progress_n_reg;
  logic siz1_reg;
  logic arb_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      burst_in_progress_n_reg <= 1'b1;
      siz1_reg <= 1'b1;
      arb_reg <= 1'b0;
    end else if (capture_evt) begin
      burst_in_progress_n_reg <= sync2_reg[3];
      siz1_reg <= sync2_reg[2];
      arb_reg <= sync2_reg[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_o <= rss_pkg::RSS_MODE_NATIVE;
    end else begin
      unique case ({burst_in_progress_n_reg, siz1_reg})
        2'b11: mode_o <= rss_pkg::RSS_MODE_NATIVE;
        2'b10: mode_o <= rss_pkg::RSS_MODE_ALT_A;
        2'b01: mode_o <= rss_pkg::RSS_MODE_ALT_B;
        2'b00: mode_o <= rss_pkg::RSS_MODE_ALT_C;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------
  logic reg_sel;
  logic br_sel;
  logic reg_wr;
  logic reg_rd;
  assign reg_sel = ~link.reg_chip_select_n;
  assign br_sel = ~link.bridge_chip_select_n;
  logic sel_d_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_d_reg <= 1'b0;
    end else begin
      sel_d_reg <= reg_sel;
    end
  end
  // one access per select assertion; the termination ends it
  assign reg_wr = reg_sel & ~sel_d_reg & ~link.write_n;
  assign reg_rd = reg_sel & ~sel_d_reg & link.write_n;

  logic soft_rst_reg;
  logic master_en_reg;
  logic host_dis_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i | hard_active) begin
      soft_rst_reg <= 1'b0;
    end else if (reg_wr && link.addr == rss_pkg::RSS_OFS_MISC_CONTROL_REG) begin
      soft_rst_reg <= link.wdata[rss_pkg::RSS_BIT_SOFT_RST];
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      master_en_reg <= 1'b0;
    end else if (hard_active) begin
      // strap sampled while global reset asserted
      master_en_reg <= sync2_reg[1];
    end else if (reg_wr && link.addr == rss_pkg::RSS_OFS_CMD_STAT) begin
      master_en_reg <= link.wdata[rss_pkg::RSS_BIT_MASTER_EN];
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      host_dis_reg <= 1'b0;
    end else if (capture_evt) begin
      // disable strap latched at reset end
      host_dis_reg <= dis_s2_reg;
    end else if (reg_wr && link.addr == rss_pkg::RSS_OFS_MISC_CONTROL_SECOND_REG &&
                 !link.wdata[rss_pkg::RSS_BIT_HOST_DIS]) begin
      host_dis_reg <= 1'b0;
    end
  end

  // reset output follows global reset and soft reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      link.reset_out_n <= 1'b0;
    end else begin
      link.reset_out_n <= ~(hard_active | soft_rst_reg);
    end
  end

  // ----------------------------------------------------------------
  // termination and target decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      link.rdata <= rss_pkg::RSS_ZERO32;
    end else if (reg_rd) begin
      unique case (link.addr)
        rss_pkg::RSS_OFS_MISC_CONTROL_REG: link.rdata <= {31'h0, soft_rst_reg};
        rss_pkg::RSS_OFS_MISC_CONTROL_SECOND_REG: link.rdata <= {31'h0, host_dis_reg};
        rss_pkg::RSS_OFS_CMD_STAT: link.rdata <= {29'h0, master_en_reg, 2'h0};
        rss_pkg::RSS_OFS_STRAPS: link.rdata <= {29'h0, burst_in_progress_n_reg, siz1_reg, arb_reg};
        default: link.rdata <= rss_pkg::RSS_ZERO32;
      endcase
    end
  end
  // bridge select terminates each burst beat unless host bus disable is set, which retries it instead
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      link.ta_n <= 1'b1;
      link.retry_n <= 1'b1;
    end else begin
      link.ta_n <= ~((reg_sel & ~sel_d_reg) | (br_sel & ~host_dis_reg));
      link.retry_n <= ~(br_sel & host_dis_reg);
    end
  end
  // image select picks the slave image
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      target_o <= rss_pkg::RSS_TGT_NONE;
      target_valid_o <= 1'b0;
    end else begin
      target_valid_o <= reg_sel | (br_sel & ~host_dis_reg);
      if (reg_sel) begin
        target_o <= rss_pkg::RSS_TGT_REGS;
      end else if (br_sel) begin
        target_o <= link.image_select ? rss_pkg::RSS_TGT_IMAGE1 : rss_pkg::RSS_TGT_IMAGE0;
      end else begin
        target_o <= rss_pkg::RSS_TGT_NONE;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      master_enable_o <= 1'b0;
      arbiter_enable_o <= 1'b0;
      host_bus_disable_o <= 1'b0;
    end else begin
      master_enable_o <= master_en_reg;
      arbiter_enable_o <= arb_reg;
      host_bus_disable_o <= host_dis_reg;
    end
  end
endmodule

// [hdl/rss_host.sv]
// processor end: drives chip selects, straps and resets from software orders
module rss_host (
  input wire logic clk_i,
  input wire logic srst_i,
  rss_link_if.host link,
  input wire logic [7:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o
);
  typedef enum logic [1:0] {RSS_H_IDLE, RSS_H_CYCLE, RSS_H_DONE} rss_hstate_t;
  rss_hstate_t state_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic [4:0] config_reg;
  logic [1:0] status_reg;
  logic [3:0] beats_reg;
  logic go;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  assign go = sw_wr_i && sw_addr_i == rss_pkg::RSS_HOFS_CTRL &&
              sw_wdata_i[rss_pkg::RSS_HC_GO] && state_reg == RSS_H_IDLE;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_reg <= 8'h00;
      addr_reg <= 8'h00;
      wdata_reg <= rss_pkg::RSS_ZERO32;
      config_reg <= 5'h18;
    end else if (sw_wr_i) begin
      unique case (sw_addr_i)
        rss_pkg::RSS_HOFS_CTRL: ctrl_reg <= sw_wdata_i[7:0];
        rss_pkg::RSS_HOFS_ADDR: addr_reg <= sw_wdata_i[7:0];
        rss_pkg::RSS_HOFS_WDATA: wdata_reg <= sw_wdata_i;
        rss_pkg::RSS_HOFS_CONFIG: config_reg <= sw_wdata_i[4:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sw_rdata_o <= rss_pkg::RSS_ZERO32;
    end else if (sw_rd_i) begin
      unique case (sw_addr_i)
        rss_pkg::RSS_HOFS_CTRL: sw_rdata_o <= {24'h0, ctrl_reg};
        rss_pkg::RSS_HOFS_ADDR: sw_rdata_o <= {24'h0, addr_reg};
        rss_pkg::RSS_HOFS_WDATA: sw_rdata_o <= wdata_reg;
        rss_pkg::RSS_HOFS_STATUS: sw_rdata_o <= {28'h0, link.reset_out_n,
                                                 state_reg != RSS_H_IDLE, status_reg};
        rss_pkg::RSS_HOFS_RDATA: sw_rdata_o <= rdata_reg;
        rss_pkg::RSS_HOFS_CONFIG: sw_rdata_o <= {27'h0, config_reg};
        default: sw_rdata_o <= rss_pkg::RSS_ZERO32;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencer: waits on external termination or retry only
  // ----------------------------------------------------------------
  // termination is registered by the device on this same clock, so it is read directly;
  // a synchroniser here would only let the select overrun the counted beats
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= RSS_H_IDLE;
      status_reg <= 2'h0;
      beats_reg <= 4'h0;
      rdata_reg <= rss_pkg::RSS_ZERO32;
    end else begin
      unique case (state_reg)
        RSS_H_IDLE: if (go) begin
          state_reg <= RSS_H_CYCLE;
          status_reg <= 2'h0;
          // bursts never issued on the register select
          beats_reg <= (sw_wdata_i[rss_pkg::RSS_HC_BURST] && sw_wdata_i[rss_pkg::RSS_HC_BRIDGE])
                       ? rss_pkg::RSS_BURST_BEATS : 4'h1;
        end
        RSS_H_CYCLE: if (!link.retry_n) begin
          state_reg <= RSS_H_DONE;
          status_reg <= 2'h2;
        end else if (!link.ta_n) begin
          rdata_reg <= link.rdata;
          beats_reg <= beats_reg - 4'h1;
          if (beats_reg == 4'h1) begin
            state_reg <= RSS_H_DONE;
            status_reg <= 2'h1;
          end
        end
        RSS_H_DONE: state_reg <= RSS_H_IDLE;
        default: state_reg <= RSS_H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      link.reg_chip_select_n <= 1'b1;
      link.bridge_chip_select_n <= 1'b1;
      link.image_select <= 1'b0;
      link.write_n <= 1'b1;
      link.addr <= 8'h00;
      link.wdata <= rss_pkg::RSS_ZERO32;
    end else begin
      link.reg_chip_select_n <= !(state_reg == RSS_H_CYCLE && !ctrl_reg[rss_pkg::RSS_HC_BRIDGE]);
      link.bridge_chip_select_n <= !(state_reg == RSS_H_CYCLE && ctrl_reg[rss_pkg::RSS_HC_BRIDGE]);
      link.image_select <= ctrl_reg[rss_pkg::RSS_HC_IMAGE];
      link.write_n <= !ctrl_reg[rss_pkg::RSS_HC_WRITE];
      // link bit 7 is most significant, software bit 7 maps to it
      link.addr <= addr_reg;
      link.wdata <= wdata_reg;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      link.host_hard_reset_n <= 1'b0;
      link.local_reset_in_n <= 1'b1;
      link.hot_swap_ok_n <= 1'b0;
      link.burst_in_progress_n <= 1'b1;
      link.size_bit_one <= 1'b1;
      link.master_enable_strap <= 1'b0;
      link.arbiter_enable_strap <= 1'b0;
      link.host_bus_disable_strap <= 1'b0;
      link.addr_strobe_n <= 1'b1;
      link.size_ack0_n <= 1'b1;
      link.done_n <= 1'b1;
    end else begin
      link.host_hard_reset_n <= !ctrl_reg[rss_pkg::RSS_HC_HRESET];
      link.local_reset_in_n <= !ctrl_reg[rss_pkg::RSS_HC_LRESET];
      link.hot_swap_ok_n <= !ctrl_reg[rss_pkg::RSS_HC_HOTSWAP];
      // strap levels while idle; the burst pin is a strap only outside cycles
      // burst pin marks remaining beats
      link.burst_in_progress_n <= (state_reg == RSS_H_CYCLE) ? (beats_reg <= 4'h1)
                                                             : config_reg[4];
      link.size_bit_one <= config_reg[3];
      link.master_enable_strap <= config_reg[2];
      link.arbiter_enable_strap <= config_reg[1];
      link.host_bus_disable_strap <= config_reg[0];
      link.addr_strobe_n <= 1'b1;
      link.size_ack0_n <= 1'b1;
      link.done_n <= 1'b1;
    end
  end
  // bridge masters synchronously on shared clk_i; no extra logic needed
endmodule

// [tb/rss_link_assertions.sv]
// checker: timing and decode relations on the link between both ends
module rss_link_assertions (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic host_hard_reset_n,
  input wire logic reset_out_n,
  input wire logic reg_chip_select_n,
  input wire logic bridge_chip_select_n,
  input wire logic image_select,
  input wire logic burst_in_progress_n,
  input wire logic [7:0] addr,
  input wire logic ta_n,
  input wire logic retry_n,
  input wire logic addr_strobe_n,
  input wire logic size_ack0_n,
  input wire logic done_n
);
  // --------------------------------------------------
  // clocking
  // --------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // --------------------------------------------------
  // properties
  // --------------------------------------------------
  chk_reset_follows: assert property (!host_hard_reset_n [*4] |-> !reset_out_n)
    else $error("reset output idle under global reset");
  chk_sel_exclusive: assert property (reg_chip_select_n || bridge_chip_select_n)
    else $error("both chip selects low");
  chk_reg_one_ta: assert property ($fell(reg_chip_select_n) |=> !ta_n ##1 ta_n)
    else $error("register cycle not terminated exactly once");
  chk_reg_single_ta: assert property (
      !reg_chip_select_n && !$past(reg_chip_select_n) |=> ta_n)
    else $error("register select terminated more than once");
  // every beat of a bridge cycle gets exactly one of termination or retry
  chk_bridge_answer: assert property (!$past(bridge_chip_select_n) |-> (ta_n ^ retry_n))
    else $error("bridge cycle beat without single answer");
  chk_ta_cause: assert property (
      !ta_n |-> (!$past(reg_chip_select_n) || !$past(bridge_chip_select_n)))
    else $error("termination without a select");
  chk_retry_cause: assert property (!retry_n |-> !$past(bridge_chip_select_n))
    else $error("retry outside a bridge cycle");
  chk_image_stable: assert property (
      !bridge_chip_select_n && !$past(bridge_chip_select_n)
      |-> $stable(image_select) && $stable(addr))
    else $error("image select moved inside a cycle");
  chk_unused_high: assert property (addr_strobe_n && size_ack0_n && done_n)
    else $error("unused strobe driven low");
  chk_reg_no_burst: assert property (!reg_chip_select_n |-> burst_in_progress_n)
    else $error("burst on register select");
endmodule

// [tb/rss_tb_top.sv]
// testbench: both ends joined, software port driven, decode and straps checked
module rss_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] sw_addr_i = 8'h00;
  logic [31:0] sw_wdata_i = 32'h0000_0000;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [31:0] sw_rdata_o;
  rss_pkg::rss_mode_t mode_o;
  rss_pkg::rss_tgt_t target_o;
  logic target_valid_o;
  logic master_enable_o;
  logic arbiter_enable_o;
  logic host_bus_disable_o;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] d;
  // rows: host reset control, strap config, expected {native, master, arbiter, disable}
  logic [7:0] row_ctl [5] = '{8'h20, 8'h40, 8'h80, 8'h20, 8'h20};
  logic [7:0] row_cfg [5] = '{8'h1C, 8'h1E, 8'h0D, 8'h10, 8'h18};
  logic [3:0] row_exp [5] = '{4'hC, 4'hE, 4'h5, 4'h0, 4'h8};
  logic [7:0] br_ctl [3] = '{8'h05, 8'h0D, 8'h1D};
  rss_pkg::rss_tgt_t br_tgt [3];
  rss_pkg::rss_tgt_t last_tgt = rss_pkg::RSS_TGT_NONE;

  rss_link_if link ();
  rss_device rss_device_i (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .link(link),
    .mode_o(mode_o),
    .target_o(target_o),
    .target_valid_o(target_valid_o),
    .master_enable_o(master_enable_o),
    .arbiter_enable_o(arbiter_enable_o),
    .host_bus_disable_o(host_bus_disable_o)
  );
  rss_host rss_host_i (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .link(link),
    .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i),
    .sw_wr_i(sw_wr_i),
    .sw_rd_i(sw_rd_i),
    .sw_rdata_o(sw_rdata_o)
  );
  rss_link_assertions rss_link_assertions_i (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .host_hard_reset_n(link.host_hard_reset_n),
    .reset_out_n(link.reset_out_n),
    .reg_chip_select_n(link.reg_chip_select_n),
    .bridge_chip_select_n(link.bridge_chip_select_n),
    .image_select(link.image_select),
    .burst_in_progress_n(link.burst_in_progress_n),
    .addr(link.addr),
    .ta_n(link.ta_n),
    .retry_n(link.retry_n),
    .addr_strobe_n(link.addr_strobe_n),
    .size_ack0_n(link.size_ack0_n),
    .done_n(link.done_n)
  );
  // target_o drops back once the select ends, so keep the last target it reported as valid
  always @(posedge clk_i) begin
    if (target_valid_o) begin
      last_tgt <= target_o;
    end
  end

  // --------------------------------------------------
  // compare and bus tasks
  // --------------------------------------------------
  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= v;
    sw_wr_i <= 1'b1;
    @(posedge clk_i);
    sw_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge clk_i);
    sw_rd_i <= 1'b0;
    #1;
    v = sw_rdata_o;
  endtask
  // start one link cycle and poll busy; a stuck busy leaves it set and fails the caller
  task automatic cyc(input logic [31:0] ctl, output logic [31:0] st);
    wr(rss_pkg::RSS_HOFS_CTRL, ctl);
    st = 32'h0000_0004;
    for (int i = 0; i < 40 && st[2] !== 1'b0; i++) begin
      rd(rss_pkg::RSS_HOFS_STATUS, st);
    end
  endtask
  task automatic dev_wr(input logic [7:0] a, input logic [31:0] v);
    wr(rss_pkg::RSS_HOFS_ADDR, {24'h00_0000, a});
    wr(rss_pkg::RSS_HOFS_WDATA, v);
    cyc(32'h0000_0003, d);
    cmp_word(d & 32'h0000_0007, 32'h0000_0001);
  endtask
  task automatic dev_rd(input logic [7:0] a, output logic [31:0] v);
    wr(rss_pkg::RSS_HOFS_ADDR, {24'h00_0000, a});
    cyc(32'h0000_0001, d);
    cmp_word(d & 32'h0000_0007, 32'h0000_0001);
    rd(rss_pkg::RSS_HOFS_RDATA, v);
  endtask
  task automatic strap_event(input logic [7:0] cfg, input logic [7:0] ctl);
    wr(rss_pkg::RSS_HOFS_CONFIG, {24'h00_0000, cfg});
    wr(rss_pkg::RSS_HOFS_CTRL, {24'h00_0000, ctl});
    repeat (6) @(posedge clk_i);
    #1;
    if (ctl[5]) cmp_bit(link.reset_out_n, 1'b0);
    wr(rss_pkg::RSS_HOFS_CTRL, 32'h0000_0000);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic close_out();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------
  // clock, watchdog and sequence
  // --------------------------------------------------
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #40000;
    n_mismatch++;
    close_out();
  end
  initial begin
    br_tgt = '{rss_pkg::RSS_TGT_IMAGE0, rss_pkg::RSS_TGT_IMAGE1, rss_pkg::RSS_TGT_IMAGE1};
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    cmp_bit(link.reset_out_n, 1'b0);
    cmp_bit(link.ta_n, 1'b1);
    for (int k = 0; k < 5; k++) begin
      strap_event(row_cfg[k], row_ctl[k]);
      cmp_bit(mode_o === rss_pkg::RSS_MODE_NATIVE, row_exp[k][3]);
      if (row_ctl[k][5]) cmp_bit(master_enable_o, row_exp[k][2]);
      cmp_bit(arbiter_enable_o, row_exp[k][1]);
      cmp_bit(host_bus_disable_o, row_exp[k][0]);
    end
    // strap pins change with no reset event: latched values must hold
    wr(rss_pkg::RSS_HOFS_CONFIG, 32'h0000_0007);
    repeat (8) @(posedge clk_i);
    cmp_bit(mode_o === rss_pkg::RSS_MODE_NATIVE, 1'b1);
    cmp_bit(arbiter_enable_o, 1'b0);
    cmp_bit(host_bus_disable_o, 1'b0);
    wr(rss_pkg::RSS_HOFS_CONFIG, 32'h0000_0018);
    dev_wr(rss_pkg::RSS_OFS_CMD_STAT, 32'h0000_0004);
    cmp_bit(master_enable_o, 1'b1);
    dev_rd(rss_pkg::RSS_OFS_CMD_STAT, d);
    cmp_bit(d[2], 1'b1);
    cmp_word(32'(last_tgt), 32'(rss_pkg::RSS_TGT_REGS));
    wr(rss_pkg::RSS_HOFS_ADDR, 32'h0000_0020);
    for (int k = 0; k < 3; k++) begin
      cyc({24'h00_0000, br_ctl[k]}, d);
      cmp_word(d & 32'h0000_0007, 32'h0000_0001);
      cmp_word(32'(last_tgt), 32'(br_tgt[k]));
    end
    dev_wr(rss_pkg::RSS_OFS_MISC_CONTROL_REG, 32'h0000_0001);
    cmp_bit(link.reset_out_n, 1'b0);
    // global reset with the disable strap high also wipes the soft reset bit
    strap_event(8'h19, 8'h20);
    cmp_bit(link.reset_out_n, 1'b1);
    cmp_bit(host_bus_disable_o, 1'b1);
    dev_rd(rss_pkg::RSS_OFS_MISC_CONTROL_REG, d);
    cmp_bit(d[0], 1'b0);
    wr(rss_pkg::RSS_HOFS_ADDR, 32'h0000_0020);
    cyc(32'h0000_0005, d);
    cmp_word(d & 32'h0000_0007, 32'h0000_0002);
    cmp_word(32'(last_tgt), 32'(rss_pkg::RSS_TGT_REGS));
    dev_wr(rss_pkg::RSS_OFS_MISC_CONTROL_SECOND_REG, 32'h0000_0000);
    cmp_bit(host_bus_disable_o, 1'b0);
    wr(rss_pkg::RSS_HOFS_ADDR, 32'h0000_0020);
    cyc(32'h0000_0005, d);
    cmp_word(d & 32'h0000_0007, 32'h0000_0001);
    cmp_word(32'(last_tgt), 32'(rss_pkg::RSS_TGT_IMAGE0));
    close_out();
  end
endmodule
